// ### rtl/fsc_regs.vh
// Purpose: Constants for the flash command controller (host side).
// Assumes: Word-wide asynchronous NOR flash with a byte-wide command set.
// Notes: Register offsets are word indices on the plain software port.
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
// Software register offsets.
`define FSC_OFF_ADDR 4'h0
`define FSC_OFF_DATA 4'h1
`define FSC_OFF_DATA2 4'h2
`define FSC_OFF_CMD 4'h3
`define FSC_OFF_STAT 4'h4
`define FSC_OFF_RDATA 4'h5
`define FSC_OFF_CFG 4'h6
// Operation codes written to the command register.
`define FSC_OP_SUSPEND 4'h1
`define FSC_OP_RESUME 4'h2
`define FSC_OP_RDARRAY 4'h3
`define FSC_OP_RDSTAT 4'h4
`define FSC_OP_CLRSTAT 4'h5
`define FSC_OP_PROG 4'h6
`define FSC_OP_DUAL 4'h7
`define FSC_OP_PRPROG 4'h8
`define FSC_OP_PRLOCK 4'h9
`define FSC_OP_IDENT 4'hA
`define FSC_OP_READ 4'hB
`define FSC_OP_POLL 4'hC
// Flash command bytes.
`define FSC_CB_SUSPEND 8'hB0
`define FSC_CB_RESUME 8'hD0
`define FSC_CB_READ 8'hFF
`define FSC_CB_PROG 8'h40
`define FSC_CB_STATUS 8'h70
`define FSC_CB_PRPROG 8'hC0
`define FSC_CB_CLEAR 8'h50
`define FSC_CB_DUAL 8'hE0
`define FSC_CB_IDENT 8'h90
// Protection register addressing.
`define FSC_PR_LOCK_WORD 16'hFFFD
`define FSC_PR_LOCK_OFS 8'h80
`define FSC_PR_FIRST 8'h81
`define FSC_PR_LAST 8'h88
`define FSC_PR_UPPER_BOT 14'h0000
`define FSC_PR_UPPER_TOP 14'h3F80
// Status bit positions.
`define FSC_SR_LOCKED 1
`define FSC_SR_SUPPLY 3
`define FSC_SR_PFAIL 4
`define FSC_SR_EFAIL 5
`define FSC_SR_PAUSED 6
`define FSC_SR_READY 7
// Bus timing: strobe low time and recovery, in ns and cycles at 4 ns.
`define FSC_CLK_NS 4
`define FSC_T_STROBE_NS 80
`define FSC_T_STROBE_CYC ((`FSC_T_STROBE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_T_GAP_NS 40
`define FSC_T_GAP_CYC ((`FSC_T_GAP_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`endif

// ### rtl/fsc_ctrl.v
// Purpose: Host controller that issues command sequences to a NOR flash.
// Assumes: Flash pins are asynchronous; data read back passes two flops.
// Notes: Software loads address and data, then writes an operation code.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_regs.vh"

// Contract
// - Suspend writes B0 to an address in the erasing plane.
// - While suspended, only sectors other than the interrupted one are touched; the code refuses only program, dual program and FSC_OP_READ in that sector.
// - D0 at any address resumes the suspended operation.
// - After read or program in suspended plane, write 70 there for status.
// - Protection program: C0 then data to target, then poll ready.
// - After the last program the host writes FF for array read.
// - Word program puts the word address on setup and data cycles.
// - Dual program: E0 then two writes differing only in address bit zero.
// - Read status: 70 then read at same plane; status on low byte.
// - Lock user block: C0 then FFFD at protection offset 80.
// - Protection upper address is 0000H bottom boot, 3F80H top boot.
module fsc_ctrl (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Software register port.
  input wire [3:0] sw_addr,
  input wire [31:0] sw_wdata,
  input wire sw_wr,
  input wire sw_rd,
  output reg [31:0] sw_rdata,
  // Flash pins.
  output reg [21:0] fl_a,
  input wire [15:0] fl_dq_i,
  output reg [15:0] fl_dq_o,
  output reg fl_dq_oe,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WR = 4'b0010;
  localparam [3:0] ST_RD = 4'b0100;
  localparam [3:0] ST_GAP = 4'b1000;
  // The counts are worked out as integers, then cut to the counter width on purpose.
  localparam integer STROBE_INT = `FSC_T_STROBE_CYC;
  localparam integer GAP_INT = `FSC_T_GAP_CYC;
  localparam [7:0] STROBE_CYC = STROBE_INT[7:0];
  localparam [7:0] GAP_CYC = GAP_INT[7:0];

  reg [3:0] state_q;
  reg [21:0] addr_q;
  reg [15:0] data_q;
  reg [15:0] data2_q;
  reg top_boot_q;
  reg [7:0] status_flags_q;
  reg [15:0] rdata_q;
  reg busy_q;
  reg err_q;
  reg paused_q;
  reg [21:0] pause_addr_q;
  reg [3:0] op_q;
  reg [1:0] step_q;
  reg [7:0] cnt_q;
  reg rd_is_stat_q;
  reg [15:0] sync1_q;
  reg [15:0] sync2_q;

  // Protection register word address, upper field set by boot variant.
  function [21:0] pr_addr;
    input top;
    input [7:0] ofs;
    begin
      pr_addr = {(top ? `FSC_PR_UPPER_TOP : `FSC_PR_UPPER_BOT), ofs};
    end
  endfunction

  // Number of bus cycles in each operation.
  function [1:0] op_len;
    input [3:0] op;
    begin
      case (op)
        `FSC_OP_PROG, `FSC_OP_PRPROG, `FSC_OP_PRLOCK, `FSC_OP_IDENT,
        `FSC_OP_RDSTAT: op_len = 2'd2;
        `FSC_OP_DUAL: op_len = 2'd3;
        default: op_len = 2'd1;
      endcase
    end
  endfunction

  // Pin data pass two flops; the first is read only by the second.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= fl_dq_i;
      sync2_q <= sync1_q;
    end
  end

  // Launch check: refusal cases computed from the requested operation.
  wire start_w = sw_wr && (sw_addr == `FSC_OFF_CMD) && !busy_q;
  wire [3:0] req_op = sw_wdata[3:0];
  wire is_prog = (req_op == `FSC_OP_PROG) || (req_op == `FSC_OP_DUAL);
  wire is_pr = (req_op == `FSC_OP_PRPROG);
  wire pr_out = (addr_q[7:0] < `FSC_PR_FIRST) || (addr_q[7:0] > `FSC_PR_LAST);
  wire same_sector = paused_q && (addr_q[21:12] == pause_addr_q[21:12]);
  wire supply_block = status_flags_q[`FSC_SR_SUPPLY] && (is_prog || is_pr);
  wire dual_bad = (req_op == `FSC_OP_DUAL) && 1'b0;
  wire refuse = supply_block || (is_pr && pr_out) || dual_bad ||
    (same_sector && (is_prog || req_op == `FSC_OP_READ));

  // Address and data for each bus step of the current operation.
  reg [21:0] step_a;
  reg [15:0] step_d;
  reg step_rd;
  always @* begin
    step_a = addr_q;
    step_d = 16'h0000;
    step_rd = 1'b0;
    case (op_q)
      `FSC_OP_SUSPEND: step_d = {8'h00, `FSC_CB_SUSPEND};
      `FSC_OP_RESUME: step_d = {8'h00, `FSC_CB_RESUME};
      `FSC_OP_RDARRAY: step_d = {8'h00, `FSC_CB_READ};
      `FSC_OP_CLRSTAT: step_d = {8'h00, `FSC_CB_CLEAR};
      `FSC_OP_POLL: step_rd = 1'b1;
      `FSC_OP_READ: step_rd = 1'b1;
      `FSC_OP_RDSTAT: begin
        step_d = {8'h00, `FSC_CB_STATUS};
        step_rd = (step_q == 2'd1);
      end
      `FSC_OP_PROG: step_d = (step_q == 2'd0) ? {8'h00, `FSC_CB_PROG} : data_q;
      `FSC_OP_DUAL: begin
        step_a = (step_q == 2'd2) ? {addr_q[21:1], 1'b1} : {addr_q[21:1], 1'b0};
        step_d = (step_q == 2'd0) ? {8'h00, `FSC_CB_DUAL} :
          ((step_q == 2'd1) ? data_q : data2_q);
      end
      `FSC_OP_PRPROG: begin
        step_a = pr_addr(top_boot_q, addr_q[7:0]);
        step_d = (step_q == 2'd0) ? {8'h00, `FSC_CB_PRPROG} : data_q;
      end
      `FSC_OP_PRLOCK: begin
        step_a = pr_addr(top_boot_q, `FSC_PR_LOCK_OFS);
        step_d = (step_q == 2'd0) ? {8'h00, `FSC_CB_PRPROG} : `FSC_PR_LOCK_WORD;
      end
      `FSC_OP_IDENT: begin
        step_d = {8'h00, `FSC_CB_IDENT};
        step_rd = (step_q == 2'd1);
      end
      default: step_d = 16'h0000;
    endcase
  end

  // Bus sequencer: each step is a recovery gap, then a timed strobe.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      op_q <= 4'h0;
      step_q <= 2'd0;
      cnt_q <= 8'h00;
      fl_a <= 22'h000000;
      fl_dq_o <= 16'h0000;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      rd_is_stat_q <= 1'b0;
      rdata_q <= 16'h0000;
      status_flags_q <= 8'h80;
      paused_q <= 1'b0;
      pause_addr_q <= 22'h000000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_w) begin
            if (refuse) begin
              err_q <= 1'b1;
            end else begin
              err_q <= 1'b0;
              op_q <= req_op;
              step_q <= 2'd0;
              busy_q <= 1'b1;
              state_q <= ST_GAP;
              cnt_q <= 8'h00;
              if (req_op == `FSC_OP_SUSPEND) begin
                pause_addr_q <= addr_q;
              end
              if (req_op == `FSC_OP_CLRSTAT) begin
                status_flags_q[`FSC_SR_LOCKED] <= 1'b0;
                status_flags_q[`FSC_SR_SUPPLY] <= 1'b0;
                status_flags_q[`FSC_SR_PFAIL] <= 1'b0;
                status_flags_q[`FSC_SR_EFAIL] <= 1'b0;
              end
              if (req_op == `FSC_OP_RESUME) begin
                paused_q <= 1'b0;
              end
            end
          end
        end
        ST_GAP: begin
          if (cnt_q >= GAP_CYC - 8'd1) begin
            cnt_q <= 8'h00;
            fl_a <= step_a;
            fl_ce_n <= 1'b0;
            rd_is_stat_q <= (op_q == `FSC_OP_RDSTAT) || (op_q == `FSC_OP_POLL);
            if (step_rd) begin
              fl_oe_n <= 1'b0;
              state_q <= ST_RD;
            end else begin
              fl_dq_o <= {8'h00, step_d[7:0]} | (step_q == 2'd0 ? 16'h0000 : step_d);
              fl_dq_oe <= 1'b1;
              fl_we_n <= 1'b0;
              state_q <= ST_WR;
            end
          end else begin
            cnt_q <= cnt_q + 8'd1;
          end
        end
        ST_WR, ST_RD: begin
          if (cnt_q >= STROBE_CYC - 8'd1) begin
            cnt_q <= 8'h00;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            if (state_q == ST_RD) begin
              rdata_q <= sync2_q;
              if (rd_is_stat_q) begin
                status_flags_q <= sync2_q[7:0];
                if (sync2_q[`FSC_SR_READY] && sync2_q[`FSC_SR_PAUSED]) begin
                  paused_q <= 1'b1;
                end
              end
            end
            if (step_q == op_len(op_q) - 2'd1) begin
              state_q <= ST_IDLE;
              busy_q <= 1'b0;
            end else begin
              step_q <= step_q + 2'd1;
              state_q <= ST_GAP;
            end
          end else begin
            cnt_q <= cnt_q + 8'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Software writable registers.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_q <= 22'h000000;
      data_q <= 16'h0000;
      data2_q <= 16'h0000;
      top_boot_q <= 1'b0;
    end else if (sw_wr && !busy_q) begin
      case (sw_addr)
        `FSC_OFF_ADDR: addr_q <= sw_wdata[21:0];
        `FSC_OFF_DATA: data_q <= sw_wdata[15:0];
        `FSC_OFF_DATA2: data2_q <= sw_wdata[15:0];
        `FSC_OFF_CFG: top_boot_q <= sw_wdata[0];
        default: top_boot_q <= top_boot_q;
      endcase
    end
  end

  // Read data stands one cycle after the read strobe; unmapped reads zero.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_rdata <= 32'h00000000;
    end else if (sw_rd) begin
      case (sw_addr)
        `FSC_OFF_ADDR: sw_rdata <= {10'h000, addr_q};
        `FSC_OFF_DATA: sw_rdata <= {16'h0000, data_q};
        `FSC_OFF_DATA2: sw_rdata <= {16'h0000, data2_q};
        `FSC_OFF_STAT: sw_rdata <= {21'h000000, paused_q, err_q, busy_q, status_flags_q};
        `FSC_OFF_RDATA: sw_rdata <= {16'h0000, rdata_q};
        `FSC_OFF_CFG: sw_rdata <= {31'h00000000, top_boot_q};
        default: sw_rdata <= 32'h00000000;
      endcase
    end else begin
      sw_rdata <= 32'h00000000;
    end
  end

endmodule // fsc_ctrl
`default_nettype wire

// ### dv/fsc_ctrl_assertions.sv
// Purpose: Pin checks of the flash command controller.
// Assumes: The command register is written only while idle.
// Notes: Flash writes are counted from each launch.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_regs.vh"
module fsc_ctrl_assertions (
  // Clock, reset and software port.
  input wire clk_sys,
  input wire rst,
  input wire [3:0] sw_addr,
  input wire [31:0] sw_wdata,
  input wire sw_wr,
  // Flash pins.
  input wire [21:0] fl_a,
  input wire [15:0] fl_dq_o,
  input wire fl_dq_oe,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n
);
  reg [3:0] op_q;
  reg [1:0] nwr_q;
  reg we_q;
  reg [21:0] adr_q;
  reg [15:0] dat_q;
  reg top_q;
  wire [13:0] up_w = top_q ? `FSC_PR_UPPER_TOP : `FSC_PR_UPPER_BOT;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Track the launched operation; the count tells which bus write is due.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_q <= 4'h0;
      nwr_q <= 2'd0;
      we_q <= 1'b1;
    end else begin
      we_q <= fl_we_n;
      if (sw_wr && sw_addr == `FSC_OFF_CMD) begin
        op_q <= sw_wdata[3:0];
        nwr_q <= 2'd0;
      end else if (we_q && !fl_we_n) begin
        nwr_q <= nwr_q + 2'd1;
      end
    end
  end
  // Operands are copied as software writes them.
  always @(posedge clk_sys) begin
    if (sw_wr && sw_addr == `FSC_OFF_ADDR) adr_q <= sw_wdata[21:0];
    if (sw_wr && sw_addr == `FSC_OFF_DATA) dat_q <= sw_wdata[15:0];
    if (sw_wr && sw_addr == `FSC_OFF_CFG) top_q <= sw_wdata[0];
  end
  a_write_qualified: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe without select or bus drive");
  a_suspend_plane: assert property ($fell(fl_we_n) && op_q == `FSC_OP_SUSPEND && nwr_q == 0
    |-> fl_dq_o[7:0] == `FSC_CB_SUSPEND && fl_a[21:20] == adr_q[21:20])
    else $error("suspend write wrong");
  a_resume_code: assert property ($fell(fl_we_n) && op_q == `FSC_OP_RESUME
    |-> nwr_q == 0 && fl_dq_o[7:0] == `FSC_CB_RESUME) else $error("resume write wrong");
  a_prog_setup: assert property ($fell(fl_we_n) && op_q == `FSC_OP_PROG && nwr_q == 0
    |-> fl_dq_o[7:0] == `FSC_CB_PROG && fl_a == adr_q) else $error("program setup wrong");
  a_prog_data: assert property ($fell(fl_we_n) && op_q == `FSC_OP_PROG && nwr_q == 1
    |-> fl_dq_o == dat_q && fl_a == adr_q) else $error("program data wrong");
  a_prot_setup: assert property ($fell(fl_we_n) && op_q == `FSC_OP_PRPROG && nwr_q == 0
    |-> fl_dq_o[7:0] == `FSC_CB_PRPROG && fl_a == {up_w, adr_q[7:0]})
    else $error("protection setup wrong");
  a_lock_word: assert property ($fell(fl_we_n) && op_q == `FSC_OP_PRLOCK && nwr_q == 1
    |-> fl_dq_o == 16'hFFFD && fl_a == {up_w, 8'h80}) else $error("lock write wrong");
  a_dual_pair: assert property ($fell(fl_we_n) && op_q == `FSC_OP_DUAL && nwr_q == 2
    |-> fl_a == {adr_q[21:1], 1'b1}) else $error("dual second address wrong");
  a_status_plane: assert property ($fell(fl_oe_n) && op_q == `FSC_OP_RDSTAT
    |-> fl_a[21:20] == adr_q[21:20]) else $error("status read in other plane");
  a_array_code: assert property ($fell(fl_we_n) && op_q == `FSC_OP_RDARRAY
    |-> fl_dq_o[7:0] == `FSC_CB_READ) else $error("array read code wrong");
  c_suspend: cover property ($fell(fl_we_n) && op_q == `FSC_OP_SUSPEND);
  c_lock: cover property ($fell(fl_we_n) && op_q == `FSC_OP_PRLOCK && nwr_q == 1);
  c_dual: cover property ($fell(fl_we_n) && op_q == `FSC_OP_DUAL && nwr_q == 2);
endmodule // fsc_ctrl_assertions
bind fsc_ctrl fsc_ctrl_assertions chk_u (.clk_sys, .rst, .sw_addr, .sw_wdata, .sw_wr,
  .fl_a, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n);
`default_nettype wire

// ### dv/fsc_flash_model.sv
// Purpose: Behavioural flash answering the controller's bus cycles.
// Assumes: A write is taken at the rising edge of the write strobe.
// Notes: The bench sets erasing to make suspends and vpp_ok to make faults.
`timescale 1ns/100ps
`default_nettype none
module fsc_flash_model #(
  parameter [15:0] MAKER = 16'h0011, // Arbitrary value.
  parameter [15:0] DEVICE = 16'h0022, // Arbitrary value.
  parameter [13:0] UPPER = 14'h3F80
) (
  // Flash pins.
  input wire [21:0] fl_a,
  input wire [15:0] fl_dq,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  output wire [15:0] fl_dq_i
);
  reg [7:0] status_flags = 8'h80;
  reg [15:0] mem [int];
  reg [15:0] pr [0:8];
  reg [15:0] out_q = 16'h0000;
  reg [2:0] st = 3'd0;
  reg [1:0] mode = 2'd0;
  reg erasing = 1'b0;
  reg vpp_ok = 1'b1;
  int busy_ns = 300;
  wire pra = fl_a[21:8] == UPPER && fl_a[7:4] == 4'h8 && fl_a[3:0] <= 4'h8;
  initial foreach (pr[i]) pr[i] = 16'hFFFF;
  // Errors are sticky; ready drops and returns later, so polls see busy.
  task automatic done(input bit lk, input bit sup, input bit fl);
    status_flags = status_flags | {3'b000, fl, sup, 1'b0, lk, 1'b0};
    status_flags[7] = 1'b0;
    status_flags[7] <= #(busy_ns) 1'b1;
    st = 3'd0;
    mode = 2'd1;
  endtask
  // The controller lifts select together with the write strobe, so select is noted as it falls.
  reg sel_q = 1'b0;
  always @(negedge fl_we_n) sel_q = !fl_ce_n;
  // Decode commands from the low data byte only; data cycles take the whole word.
  always @(posedge fl_we_n) if (sel_q) begin
    case (st)
      3'd1: begin
        if (vpp_ok && !status_flags[3]) mem[fl_a] = fl_dq;
        done(1'b0, !vpp_ok, !vpp_ok);
      end
      3'd2: if (!pra) done(1'b0, 1'b0, 1'b1);
        else if (fl_a[3:0] != 0 && !pr[0][1]) done(1'b1, 1'b0, 1'b1);
        else begin
          pr[fl_a[3:0]] = pr[fl_a[3:0]] & fl_dq;
          done(1'b0, 1'b0, 1'b0);
        end
      3'd3: begin
        mem[fl_a] = fl_dq;
        st = 3'd4;
      end
      3'd4: begin
        mem[fl_a] = fl_dq;
        done(1'b0, 1'b0, 1'b0);
      end
      default: case (fl_dq[7:0])
        8'hFF: mode = 2'd0;
        8'h70: mode = 2'd1;
        8'h90: mode = 2'd2;
        8'h50: status_flags = status_flags & 8'hC5;
        8'h40, 8'h10: st = 3'd1;
        8'hC0: st = 3'd2;
        8'hE0: st = 3'd3;
        8'hD0: status_flags[6] = 1'b0;
        8'hB0: begin
          status_flags[6] = erasing;
          done(1'b0, 1'b0, 1'b0);
        end
        default: st = 3'd0;
      endcase
    endcase
  end
  // Read data appear at the output strobe; a released bus shows the inverse.
  always @(negedge fl_oe_n) out_q = mode == 2'd1 ? {8'h00, status_flags} :
    mode == 2'd0 ? (mem.exists(fl_a) ? mem[fl_a] : 16'hFFFF) :
    fl_a[7:0] == 8'h00 ? MAKER : fl_a[7:0] == 8'h01 ? DEVICE : pr[fl_a[3:0]];
  always @(posedge fl_oe_n) out_q = ~out_q;
  assign fl_dq_i = out_q;
endmodule // fsc_flash_model
`default_nettype wire

// ### dv/flash_suspend_protect_cmds_bench.sv
// Purpose: Self-checking bench of the flash command controller.
// Assumes: Operations are launched only while the controller is idle.
// Notes: Every operation waits for the busy bit under a bound.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_regs.vh"
module flash_suspend_protect_cmds_bench;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [3:0] sw_addr = 4'h0;
  reg [31:0] sw_wdata = 32'h0;
  reg sw_wr = 1'b0;
  reg sw_rd = 1'b0;
  wire [31:0] sw_rdata;
  wire [21:0] fl_a;
  wire [15:0] fl_dq_i;
  wire [15:0] fl_dq_o;
  wire fl_dq_oe;
  wire fl_ce_n;
  wire fl_oe_n;
  wire fl_we_n;
  int miscompares = 0;
  int checks = 0;
  reg [31:0] r;
  always #2 clk_sys = ~clk_sys;
  fsc_ctrl dut_u (.clk_sys, .rst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .fl_a,
    .fl_dq_i, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n);
  fsc_flash_model mdl_u (.fl_a, .fl_dq(fl_dq_o), .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_i);
  task finish_test;
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register accesses keep one idle cycle so a strobe is never re-driven at once.
  task wr(input [3:0] a, input [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input [3:0] a, output [31:0] d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    @(negedge clk_sys);
    d = sw_rdata;
    @(posedge clk_sys);
  endtask
  task op(input [3:0] o);
    int n;
    wr(`FSC_OFF_CMD, {28'h0, o});
    n = 0;
    do begin
      rd(`FSC_OFF_STAT, r);
      n++;
    end while (r[8] && n < 400);
    if (n >= 400) begin
      miscompares++;
      finish_test;
    end
  endtask
  // Status polls repeat until the flash reports ready.
  task poll;
    int n;
    n = 0;
    do begin
      op(`FSC_OP_POLL);
      n++;
    end while (!r[7] && n < 50);
    if (n >= 50) begin
      miscompares++;
      finish_test;
    end
  endtask
  task rdback(input [21:0] a, input [15:0] e);
    wr(`FSC_OFF_ADDR, {10'h0, a});
    op(`FSC_OP_RDARRAY);
    op(`FSC_OP_READ);
    rd(`FSC_OFF_RDATA, r);
    chk(r[15:0], e);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`FSC_OFF_STAT, r);
    chk(r[10:0], 11'h080);
    wr(`FSC_OFF_CFG, 32'h1);
    wr(`FSC_OFF_ADDR, 32'h012345);
    wr(`FSC_OFF_DATA, 32'hA5A5);
    op(`FSC_OP_PROG);
    poll;
    chk(r[10:0], 11'h080);
    rdback(22'h012345, 16'hA5A5);
    wr(`FSC_OFF_ADDR, 32'h100010);
    wr(`FSC_OFF_DATA2, 32'h2222);
    op(`FSC_OP_DUAL);
    poll;
    rdback(22'h100011, 16'h2222);
    mdl_u.erasing = 1'b1;
    wr(`FSC_OFF_ADDR, 32'h205000);
    op(`FSC_OP_SUSPEND);
    poll;
    chk(r[10:0], 11'h4C0);
    rdback(22'h012345, 16'hA5A5);
    wr(`FSC_OFF_ADDR, 32'h205010);
    op(`FSC_OP_PROG);
    chk(r[9], 1'b1);
    op(`FSC_OP_RDSTAT);
    op(`FSC_OP_RESUME);
    poll;
    chk(r[7:6], 2'b10);
    mdl_u.erasing = 1'b0;
    op(`FSC_OP_SUSPEND);
    poll;
    chk(r[7:6], 2'b10);
    wr(`FSC_OFF_ADDR, 32'h85);
    wr(`FSC_OFF_DATA, 32'hBEEF);
    op(`FSC_OP_PRPROG);
    poll;
    op(`FSC_OP_IDENT);
    rd(`FSC_OFF_RDATA, r);
    chk(r[15:0], 16'hBEEF);
    wr(`FSC_OFF_ADDR, 32'h90);
    op(`FSC_OP_PRPROG);
    chk(r[9], 1'b1);
    op(`FSC_OP_PRLOCK);
    poll;
    wr(`FSC_OFF_ADDR, 32'h80);
    op(`FSC_OP_IDENT);
    rd(`FSC_OFF_RDATA, r);
    chk(r[1], 1'b0);
    wr(`FSC_OFF_ADDR, 32'h86);
    op(`FSC_OP_PRPROG);
    poll;
    chk(r[4:1], 4'b1001);
    op(`FSC_OP_CLRSTAT);
    poll;
    chk(r[5:1], 5'h00);
    mdl_u.vpp_ok = 1'b0;
    wr(`FSC_OFF_ADDR, 32'h013000);
    op(`FSC_OP_PROG);
    poll;
    chk(r[4:1], 4'b1100);
    op(`FSC_OP_PROG);
    chk(r[9], 1'b1);
    finish_test;
  end
endmodule // flash_suspend_protect_cmds_bench
`default_nettype wire
